// ### src/comm_status_unit.sv
/*
 * Communication status unit of a fieldbus stepper drive: emergency message
 * source, run/error/link lamps, save and restore signature detection and
 * start-up step tracking, with an APB register slave.
 * Assumes all inputs are synchronous to clk_i and the mailbox layer
 * presents each decoded object write as a one-cycle strobe.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module comm_status_unit #(
    parameter int unsigned TICK_CYCLES = comm_status_pkg::TICK_CYCLES_DEF  // Lamp tick
) (
    input wire logic clk_i,                // System clock, 10 MHz
    input wire logic rst_i,                // Async reset, active high
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB access phase
    input wire logic pwrite,               // APB write
    input wire logic [11:0] paddr,         // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error, unmapped address
    input wire logic fault_event_i,        // Warning or alarm event pulse
    input wire logic [15:0] fault_code_i,  // Code of that event
    input wire logic [7:0] fault_reg_i,    // Error register of that event
    output logic [7:0] emcy_data_o,        // Emergency message byte
    output logic emcy_valid_o,             // Byte valid
    output logic emcy_last_o,              // Last byte of message
    input wire logic emcy_ready_i,         // Byte taken
    input wire logic obj_wr_i,             // Object write strobe
    input wire logic obj_pdo_i,            // Write came by process data
    input wire logic [6:0] obj_len_i,      // Transfer size in bytes
    input wire logic [15:0] obj_index_i,   // Object index
    input wire logic [7:0] obj_sub_i,      // Object subindex
    input wire logic [31:0] obj_data_i,    // Object value
    output logic save_req_o,               // Save parameters pulse
    output logic [15:0] save_lo_o,         // First index to save
    output logic [15:0] save_hi_o,         // Last index to save
    output logic restore_req_o,            // Restore defaults pulse
    output logic step_report_o,            // Start-up step reported pulse
    input wire logic link_in_up_i,         // Input port link up
    input wire logic link_in_act_i,        // Input port traffic pulse
    input wire logic link_out_up_i,        // Output port link up
    input wire logic link_out_act_i,       // Output port traffic pulse
    output logic state_machine_lamp_o,     // Green run lamp
    output logic fault_lamp_position_o,    // Red error lamp
    output logic link_in_lamp_o,           // Green input port lamp
    output logic link_out_lamp_o           // Green output port lamp
);
    import comm_status_pkg::*;

    typedef struct packed {
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic [PHASE_W-1:0] phase;
        comm_state_t comm_state;
        lamp_pat_t err_pat;
        logic [15:0] latest_code;
        logic [3:0] sticky;        // save, restore, ignored, size error
        startup_t step;
        logic emcy_active;
        logic [3:0] emcy_idx;
        logic [7:0] emcy_data;
        logic [15:0] emcy_code;
        logic [7:0] emcy_ereg;
        logic pend;
        logic [15:0] pend_code;
        logic [7:0] pend_ereg;
        logic [15:0] emcy_cnt;
        logic act_in;
        logic act_out;
        logic save_pulse;
        logic restore_pulse;
        logic report_pulse;
    } unit_state_t;

    unit_state_t s_reg;
    unit_state_t s_next;

    // Byte n of an emergency message, little-endian words
    function automatic logic [7:0] emcy_byte(input logic [3:0] idx, input logic [15:0] code,
                                             input logic [7:0] ereg, input logic [15:0] latest);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            EMCY_IDX_LEN: b = EMCY_BODY_LEN;
            EMCY_IDX_TYPE: b = MBX_TYPE_COE;
            EMCY_IDX_CMD: b = CMD_TYPE_EMCY;
            EMCY_IDX_CODE: b = code[7:0];
            EMCY_IDX_CODE + 4'h1: b = code[15:8];
            EMCY_IDX_EREG: b = ereg;
            EMCY_IDX_USER: b = latest[7:0];
            EMCY_IDX_USER + 4'h1: b = latest[15:8];
            default: b = 8'h00;                              // Header padding bytes and upper user bytes
        endcase
        return b;
    endfunction

    logic obj_size_ok;
    logic sig_write;
    logic apb_wr;
    logic emcy_done;
    lamp_pat_t run_pat;

    assign apb_wr = psel && penable && pwrite;
    assign emcy_done = s_reg.emcy_active && emcy_ready_i && (s_reg.emcy_idx == EMCY_LAST_IDX);
    // Oversized frames are refused whole rather than truncated
    assign obj_size_ok = obj_pdo_i ? (obj_len_i <= PDO_MAX_BYTES)
                                   : (obj_len_i == SDO_EXP_BYTES);
    assign sig_write = obj_wr_i && obj_size_ok && (obj_sub_i == SUB_SIGNATURE) &&
        ((obj_index_i == OBJ_STORE) || (obj_index_i == OBJ_RESTORE));

    always_comb begin
        s_next = s_reg;
        s_next.save_pulse = 1'b0;
        s_next.restore_pulse = 1'b0;
        s_next.report_pulse = 1'b0;

        // Lamp time base
        if (s_reg.tick_cnt >= TICK_CNT_W'(TICK_CYCLES - 1)) begin
            s_next.tick_cnt = '0;
            s_next.phase = s_reg.phase + 5'h01;
            s_next.act_in = 1'b0;
            s_next.act_out = 1'b0;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 20'h00001;
        end
        // Traffic is stretched to the next tick so short bursts show
        if (link_in_act_i) begin
            s_next.act_in = 1'b1;
        end
        if (link_out_act_i) begin
            s_next.act_out = 1'b1;
        end

        // Emergency message sender with one pending slot
        if (s_reg.emcy_active && emcy_ready_i && !emcy_done) begin
            s_next.emcy_idx = s_reg.emcy_idx + 4'h1;
            s_next.emcy_data = emcy_byte(s_reg.emcy_idx + 4'h1, s_reg.emcy_code,
                                         s_reg.emcy_ereg, s_reg.latest_code);
        end
        if (!s_reg.emcy_active || emcy_done) begin
            s_next.emcy_active = 1'b0;
            if (s_reg.pend || fault_event_i) begin
                s_next.emcy_active = 1'b1;
                s_next.emcy_idx = EMCY_IDX_LEN;
                s_next.emcy_data = emcy_byte(EMCY_IDX_LEN, 16'h0000, 8'h00, 16'h0000);
                s_next.emcy_code = s_reg.pend ? s_reg.pend_code : fault_code_i;
                s_next.emcy_ereg = s_reg.pend ? s_reg.pend_ereg : fault_reg_i;
                s_next.pend = s_reg.pend && fault_event_i;
                s_next.emcy_cnt = s_reg.emcy_cnt + 16'h0001;
            end
        end else if (fault_event_i) begin
            s_next.pend = 1'b1;  // A newer event replaces an older waiting one
        end
        if (fault_event_i) begin
            s_next.pend_code = fault_code_i;
            s_next.pend_ereg = fault_reg_i;
        end

        // APB register writes; sticky bits clear by writing one
        if (apb_wr && (paddr == REG_COMM)) begin
            s_next.comm_state = comm_state_t'(pwdata[COMM_STATE_LSB +: 2]);
            s_next.err_pat = lamp_pat_t'(pwdata[ERR_PAT_LSB +: 3]);
        end
        if (apb_wr && (paddr == REG_LATEST)) begin
            s_next.latest_code = pwdata[15:0];
        end
        if (apb_wr && (paddr == REG_STATUS)) begin
            s_next.sticky = s_reg.sticky & ~pwdata[ST_STICKY_LSB +: 4];
        end
        // Events after the clear so that a set in the same cycle wins
        if (fault_event_i) begin
            s_next.latest_code = fault_code_i;
        end
        if (obj_wr_i && !obj_size_ok) begin
            s_next.sticky[3] = 1'b1;
        end

        // Save and restore signatures
        if (sig_write) begin
            if ((obj_index_i == OBJ_STORE) && (obj_data_i == SIG_SAVE)) begin
                s_next.save_pulse = 1'b1;
                s_next.sticky[0] = 1'b1;
            end else if (obj_data_i == SIG_LOAD) begin
                s_next.restore_pulse = 1'b1;
                s_next.sticky[1] = 1'b1;
            end else begin
                s_next.sticky[2] = 1'b1;
            end
        end

        // Start-up step tracking
        if (obj_wr_i && obj_size_ok) begin
            unique case (s_reg.step)
                SU_WAIT_CTRL: if (obj_index_i == OBJ_CTRL_WORD) begin
                    s_next.step = SU_CTRL_SEEN;
                end
                SU_CTRL_SEEN: if ((obj_index_i == OBJ_CTRL_WORD) &&
                                  (obj_data_i[3:0] == CTRL_ENABLE_OP)) begin
                    s_next.step = SU_ENABLED;
                end
                SU_ENABLED: if ((obj_index_i == OBJ_OP_MODE) &&
                                (obj_data_i[7:0] == MODE_HOMING)) begin
                    s_next.step = SU_HOMING;
                end
                SU_HOMING: if ((obj_index_i == OBJ_TARGET_POS) ||
                               (obj_index_i == OBJ_TARGET_VEL)) begin
                    s_next.step = SU_MOTION;
                end
                SU_MOTION: s_next.step = SU_MOTION;
                default: s_next.step = SU_WAIT_CTRL;
            endcase
            s_next.report_pulse = (s_next.step != s_reg.step);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Register read mux; zero-wait slave
    always_comb begin
        prdata = 32'h00000000;
        pslverr = 1'b0;
        unique case (paddr)
            REG_COMM: begin
                prdata[COMM_STATE_LSB +: 2] = s_reg.comm_state;
                prdata[ERR_PAT_LSB +: 3] = s_reg.err_pat;
            end
            REG_LATEST: prdata[15:0] = s_reg.latest_code;
            REG_STATUS: begin
                prdata[ST_BUSY_BIT] = s_reg.emcy_active;
                prdata[ST_PEND_BIT] = s_reg.pend;
                prdata[ST_STICKY_LSB +: 4] = s_reg.sticky;
                prdata[ST_STEP_LSB +: 3] = s_reg.step;
            end
            REG_EMCY_CNT: prdata[15:0] = s_reg.emcy_cnt;
            default: pslverr = psel && penable;
        endcase
    end
    assign pready = 1'b1;

    // Run lamp follows the communication state
    always_comb begin
        unique case (s_reg.comm_state)
            CS_INIT: run_pat = LP_OFF;
            CS_PREOP: run_pat = LP_BLINK;
            CS_SAFEOP: run_pat = LP_SINGLE;
            CS_OP: run_pat = LP_ON;
        endcase
    end

    lamp_if lif[4] ();
    assign lif[0].pattern = run_pat;
    assign lif[1].pattern = s_reg.err_pat;
    assign lif[2].pattern = !link_in_up_i ? LP_OFF : (s_reg.act_in ? LP_FLICKER : LP_ON);
    assign lif[3].pattern = !link_out_up_i ? LP_OFF : (s_reg.act_out ? LP_FLICKER : LP_ON);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lamp
            assign lif[gi].phase = s_reg.phase;
            lamp_pattern u_lamp (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .bus(lif[gi])
            );
        end
    endgenerate

    assign state_machine_lamp_o = lif[0].lamp;
    assign fault_lamp_position_o = lif[1].lamp;
    assign link_in_lamp_o = lif[2].lamp;
    assign link_out_lamp_o = lif[3].lamp;
    assign emcy_data_o = s_reg.emcy_data;
    assign emcy_valid_o = s_reg.emcy_active;
    assign emcy_last_o = s_reg.emcy_active && (s_reg.emcy_idx == EMCY_LAST_IDX);
    assign save_req_o = s_reg.save_pulse;
    assign save_lo_o = SAVE_IDX_LO;
    assign save_hi_o = SAVE_IDX_HI;
    assign restore_req_o = s_reg.restore_pulse;
    assign step_report_o = s_reg.report_pulse;

    sequence s_idle_event;
        fault_event_i && !s_reg.emcy_active && !s_reg.pend;
    endsequence
    sequence s_msg_opens;
        emcy_valid_o && (emcy_data_o == EMCY_BODY_LEN) && (s_reg.emcy_idx == EMCY_IDX_LEN);
    endsequence

    a_emcy_on_event: assert property (@(posedge clk_i) disable iff (rst_i)
        s_idle_event |=> s_msg_opens)
        else $error("no emergency message after event");
    a_emcy_type_bytes: assert property (@(posedge clk_i) disable iff (rst_i)
        emcy_valid_o && s_reg.emcy_idx == EMCY_IDX_TYPE |-> emcy_data_o == MBX_TYPE_COE)
        else $error("wrong mailbox type byte");
    a_emcy_cmd_byte: assert property (@(posedge clk_i) disable iff (rst_i)
        emcy_valid_o && s_reg.emcy_idx == EMCY_IDX_CMD |-> emcy_data_o == CMD_TYPE_EMCY)
        else $error("wrong command type byte");
    a_user_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        emcy_valid_o && s_reg.emcy_idx > EMCY_IDX_USER + 4'h1 |-> emcy_data_o == 8'h00)
        else $error("upper user bytes not zero");
    a_save_signature: assert property (@(posedge clk_i) disable iff (rst_i)
        sig_write && obj_index_i == OBJ_STORE && obj_data_i == SIG_SAVE
        |=> save_req_o && !restore_req_o)
        else $error("save signature not acted on");
    a_restore_signature: assert property (@(posedge clk_i) disable iff (rst_i)
        sig_write && obj_data_i == SIG_LOAD |=> restore_req_o && !save_req_o)
        else $error("restore signature not acted on");
    a_bad_sig_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        sig_write && obj_data_i != SIG_SAVE && obj_data_i != SIG_LOAD
        |=> !save_req_o && !restore_req_o && s_reg.sticky[2])
        else $error("bad signature acted on");
    a_size_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        obj_wr_i && obj_pdo_i && obj_len_i > PDO_MAX_BYTES |=> !save_req_o && s_reg.sticky[3])
        else $error("oversized process data accepted");
    a_step_report: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(s_reg.step) |-> step_report_o)
        else $error("start-up step not reported");
    a_run_lamp_op: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.comm_state == CS_OP [*2] |-> state_machine_lamp_o)
        else $error("run lamp dark in operational");
endmodule

// ### src/comm_status_pkg.sv
/*
 * Constants, types and register map of the drive communication status unit.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
package comm_status_pkg;

    // Clock and lamp timing
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int TICK_TIME_MS = 50;
    localparam int TICK_CYCLES_DEF = TICK_TIME_MS * CLK_FREQ_KHZ;
    localparam int TICK_CNT_W = 20;
    localparam int PHASE_W = 5;

    // Lamp phase windows, in ticks of a 32-tick frame
    localparam logic [PHASE_W-1:0] FLASH_ON_END = 5'h04;
    localparam logic [PHASE_W-1:0] FLASH2_BEG = 5'h08;
    localparam logic [PHASE_W-1:0] FLASH2_END = 5'h0c;
    localparam int BLINK_BIT = 2;

    // APB register byte offsets
    localparam logic [11:0] REG_COMM = 12'h000;
    localparam logic [11:0] REG_LATEST = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_EMCY_CNT = 12'h00c;

    // Field positions
    localparam int COMM_STATE_LSB = 0;
    localparam int ERR_PAT_LSB = 4;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PEND_BIT = 1;
    localparam int ST_STICKY_LSB = 8;
    localparam int ST_STEP_LSB = 16;
    localparam logic [3:0] STICKY_RESET = 4'h0;

    // Object dictionary addresses and signatures
    localparam logic [15:0] OBJ_STORE = 16'h1010;
    localparam logic [15:0] OBJ_RESTORE = 16'h1011;
    localparam logic [7:0] SUB_SIGNATURE = 8'h04;
    localparam logic [31:0] SIG_SAVE = 32'h65766173;
    localparam logic [31:0] SIG_LOAD = 32'h64616f6c;
    localparam logic [15:0] SAVE_IDX_LO = 16'h2000;
    localparam logic [15:0] SAVE_IDX_HI = 16'h5fff;
    localparam logic [15:0] OBJ_CTRL_WORD = 16'h6040;
    localparam logic [15:0] OBJ_OP_MODE = 16'h6060;
    localparam logic [15:0] OBJ_TARGET_POS = 16'h607a;
    localparam logic [15:0] OBJ_TARGET_VEL = 16'h60ff;
    localparam logic [3:0] CTRL_ENABLE_OP = 4'hf;
    localparam logic [7:0] MODE_HOMING = 8'h06;

    // Transfer sizes in bytes
    localparam logic [6:0] PDO_MAX_BYTES = 7'h40;
    localparam logic [6:0] SDO_EXP_BYTES = 7'h04;

    // Emergency message layout
    localparam logic [3:0] EMCY_LAST_IDX = 4'hf;
    localparam logic [7:0] EMCY_BODY_LEN = 8'h0a;
    localparam logic [7:0] MBX_TYPE_COE = 8'h03;
    localparam logic [7:0] CMD_TYPE_EMCY = 8'h10;
    localparam logic [3:0] EMCY_IDX_LEN = 4'h0;
    localparam logic [3:0] EMCY_IDX_TYPE = 4'h5;
    localparam logic [3:0] EMCY_IDX_CMD = 4'h7;
    localparam logic [3:0] EMCY_IDX_CODE = 4'h8;
    localparam logic [3:0] EMCY_IDX_EREG = 4'ha;
    localparam logic [3:0] EMCY_IDX_USER = 4'hb;

    typedef enum logic [2:0] {
        LP_OFF, LP_ON, LP_BLINK, LP_SINGLE, LP_DOUBLE, LP_FLICKER
    } lamp_pat_t;

    typedef enum logic [1:0] {
        CS_INIT, CS_PREOP, CS_SAFEOP, CS_OP
    } comm_state_t;

    typedef enum logic [2:0] {
        SU_WAIT_CTRL, SU_CTRL_SEEN, SU_ENABLED, SU_HOMING, SU_MOTION
    } startup_t;

endpackage

// ### src/lamp_if.sv
/*
 * Carrier between the status unit and one lamp pattern generator.
 * Assumes the shared phase and pattern come from the same clock domain.
 */
`timescale 1ns/1ps
interface lamp_if;
    import comm_status_pkg::*;
    lamp_pat_t pattern;
    logic [PHASE_W-1:0] phase;
    logic lamp;

    modport ctrl (output pattern, output phase, input lamp);
    modport gen (input pattern, input phase, output lamp);
endinterface

// ### src/lamp_pattern.sv
/*
 * One indicator lamp: turns a pattern code and the shared frame phase
 * into a registered lamp level. Assumes phase advances once per tick.
 */
`timescale 1ns/1ps
module lamp_pattern (
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Async reset, active high
    lamp_if.gen bus          // Pattern in, lamp out
);
    import comm_status_pkg::*;

    typedef struct packed {
        logic lamp;
    } lamp_state_t;

    lamp_state_t s_reg;
    lamp_state_t s_next;

    // Pattern decode against the frame phase
    always_comb begin
        s_next = s_reg;
        unique case (bus.pattern)
            LP_OFF: s_next.lamp = 1'b0;
            LP_ON: s_next.lamp = 1'b1;
            LP_BLINK: s_next.lamp = bus.phase[BLINK_BIT];
            LP_SINGLE: s_next.lamp = (bus.phase < FLASH_ON_END);
            LP_DOUBLE: s_next.lamp = (bus.phase < FLASH_ON_END) ||
                ((bus.phase >= FLASH2_BEG) && (bus.phase < FLASH2_END));
            LP_FLICKER: s_next.lamp = bus.phase[0];
            default: s_next.lamp = 1'b0;  // Unused codes keep the lamp dark
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.lamp = s_reg.lamp;

    a_lamp_steady_on: assert property (@(posedge clk_i) disable iff (rst_i)
        bus.pattern == LP_ON |=> bus.lamp)
        else $error("lamp not lit for steady pattern");
    a_lamp_steady_off: assert property (@(posedge clk_i) disable iff (rst_i)
        bus.pattern == LP_OFF |=> !bus.lamp)
        else $error("lamp lit for off pattern");
endmodule

// ### tb/emcy_sink.sv
/*
 * Stand-in for the master's mailbox layer taking emergency bytes.
 * Assumes a byte moves on valid and ready at a rising edge.
 */
`timescale 1ns/1ps
module emcy_sink (
    input wire logic clk_i,         // System clock
    input wire logic rst_i,         // Async reset, active high
    input wire logic slow_i,        // Stall every other cycle
    input wire logic [7:0] data_i,  // Byte in
    input wire logic valid_i,       // Byte valid
    input wire logic last_i,        // Last byte flag
    output logic ready_o            // Byte taken
);
    logic [7:0] msg [32];
    logic lm [32];
    int n;

    // Stalls prove the unit holds each byte until it is taken
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            n <= 0;
        end else begin
            ready_o <= slow_i ? ~ready_o : 1'b1;
            if (valid_i && ready_o && n < 32) begin
                msg[n] <= data_i;
                lm[n] <= last_i;
                n <= n + 1;
            end
        end
    end
endmodule

// ### tb/tb_top.sv
/*
 * Self-checking bench for the comm status unit: APB and object write tasks.
 * Assumes the emergency sink model on the byte stream and a 4-cycle tick.
 */
`timescale 1ns/1ps
module tb_top;
    import comm_status_pkg::*;
    logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, obj_data_i = 0, rd;
    logic fault_event_i = 0, emcy_valid_o, emcy_last_o, emcy_ready_i, obj_wr_i = 0;
    logic [15:0] fault_code_i = 0, obj_index_i = 0, save_lo_o, save_hi_o;
    logic [7:0] fault_reg_i = 0, emcy_data_o, obj_sub_i = 0;
    logic [6:0] obj_len_i = 0;
    logic obj_pdo_i = 0, save_req_o, restore_req_o, step_report_o, slow = 1;
    logic link_in_up_i = 0, link_in_act_i = 0, link_out_up_i = 0, link_out_act_i = 0;
    logic state_machine_lamp_o, fault_lamp_position_o, link_in_lamp_o, link_out_lamp_o;
    logic [2:0] p3;
    int fail_count = 0, n_checks = 0, k, c[4];
    int rs[4] = '{0, 64, 16, 128};
    int es[6] = '{0, 128, 64, 16, 32, 64};

    comm_status_unit #(.TICK_CYCLES(4)) i_dut (.clk_i, .rst_i, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_event_i, .fault_code_i,
        .fault_reg_i, .emcy_data_o, .emcy_valid_o, .emcy_last_o, .emcy_ready_i, .obj_wr_i,
        .obj_pdo_i, .obj_len_i, .obj_index_i, .obj_sub_i, .obj_data_i, .save_req_o,
        .save_lo_o, .save_hi_o, .restore_req_o, .step_report_o, .link_in_up_i,
        .link_in_act_i, .link_out_up_i, .link_out_act_i, .state_machine_lamp_o,
        .fault_lamp_position_o, .link_in_lamp_o, .link_out_lamp_o);
    emcy_sink i_sink (.clk_i, .rst_i, .slow_i(slow), .data_i(emcy_data_o),
        .valid_i(emcy_valid_o), .last_i(emcy_last_o), .ready_o(emcy_ready_i));

    always #50 clk_i = ~clk_i;

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tmo(input int lim);
        if (k >= lim) begin
            fail_count++;
            close_out();
        end
    endtask

    // Setup, then access until ready; data taken at that edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        tmo(20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle object write strobe; pulses are read once the next edge has landed
    task automatic obj(input logic [15:0] i, input logic [31:0] d, input logic [6:0] l,
        input logic p);
        @(posedge clk_i);
        obj_wr_i <= 1'b1;
        obj_index_i <= i;
        obj_sub_i <= SUB_SIGNATURE;
        obj_data_i <= d;
        obj_len_i <= l;
        obj_pdo_i <= p;
        @(posedge clk_i);
        obj_wr_i <= 1'b0;
        #1;
        p3 = {save_req_o, restore_req_o, step_report_o};
    endtask

    // Expected message byte; latest code is 0x0102 when the user area is loaded
    function automatic logic [7:0] eb(input int i, input logic [15:0] c, input logic [7:0] r);
        case (i % 16)
            0: return EMCY_BODY_LEN;
            5: return MBX_TYPE_COE;
            7: return CMD_TYPE_EMCY;
            8: return c[7:0];
            9: return c[15:8];
            10: return r;
            11: return 8'h02;
            12: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(0, REG_COMM, 32'h0);
        chk(rd, 32'h0);
        apb(0, 12'h010, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        $display("test registers done");
        // Two events back to back: the second waits in the pending slot
        apb(1, REG_LATEST, 32'h1234);
        @(posedge clk_i);
        fault_event_i <= 1'b1;
        fault_code_i <= 16'hbeef;
        fault_reg_i <= 8'h81;
        @(posedge clk_i);
        fault_code_i <= 16'h0102;
        fault_reg_i <= 8'h02;
        @(posedge clk_i);
        fault_event_i <= 1'b0;
        // First message still going out and the second waiting in its slot
        apb(0, REG_STATUS, 32'h0);
        chk(rd[1:0], 32'h3);
        k = 0;
        while (i_sink.n < 32 && k < 500) begin
            @(posedge clk_i);
            k++;
            slow <= i_sink.n < 16;  // Second message stalls once on its first byte, then is taken with no stalls
        end
        tmo(500);
        for (int i = 0; i < 32; i++) begin
            chk(i_sink.msg[i], eb(i, i < 16 ? 16'hbeef : 16'h0102, i < 16 ? 8'h81 : 8'h02));
            chk(i_sink.lm[i], (i % 16) == 15);
        end
        apb(0, REG_EMCY_CNT, 32'h0);
        chk(rd[15:0], 32'h2);
        apb(0, REG_LATEST, 32'h0);
        chk(rd[15:0], 32'h0102);
        $display("test emergency done");
        obj(OBJ_STORE, SIG_SAVE, 7'h04, 0);
        chk(p3, 32'h4);
        chk({save_lo_o, save_hi_o}, 32'h2000_5fff);
        obj(OBJ_RESTORE, SIG_LOAD, 7'h04, 0);
        chk(p3, 32'h2);
        obj(OBJ_STORE, SIG_LOAD, 7'h04, 0);
        chk(p3, 32'h2);
        obj(OBJ_STORE, 32'h65766174, 7'h04, 0);
        chk(p3, 32'h0);
        obj(OBJ_STORE, SIG_SAVE, 7'h08, 0);
        chk(p3, 32'h0);
        obj(OBJ_CTRL_WORD, 32'h6, 7'h41, 1);
        chk(p3, 32'h0);
        obj(OBJ_CTRL_WORD, 32'h6, PDO_MAX_BYTES, 1);
        chk(p3, 32'h1);
        obj(OBJ_CTRL_WORD, 32'hf, SDO_EXP_BYTES, 0);
        chk(p3, 32'h1);
        obj(OBJ_OP_MODE, 32'(MODE_HOMING), 7'h04, 0);
        chk(p3, 32'h1);
        obj(OBJ_TARGET_VEL, 32'h100, 7'h04, 0);
        chk(p3, 32'h1);
        apb(0, REG_STATUS, 32'h0);
        chk(rd[18:8], 32'h40f);
        apb(1, REG_STATUS, 32'h0f00);
        apb(0, REG_STATUS, 32'h0);
        chk(rd[11:8], 32'h0);
        $display("test objects done");
        // Each lamp counted over one full 128-cycle frame
        for (int p = 0; p < 6; p++) begin
            apb(1, REG_COMM, 32'(p * 16 + p % 4));
            link_in_up_i <= p > 0;
            link_in_act_i <= p == 3;
            link_out_up_i <= p[0];
            link_out_act_i <= p == 5;
            repeat (8) @(posedge clk_i);
            c = '{default: 0};
            repeat (128) begin
                @(posedge clk_i);
                c[0] += state_machine_lamp_o;
                c[1] += fault_lamp_position_o;
                c[2] += link_in_lamp_o;
                c[3] += link_out_lamp_o;
            end
            chk(c[0], rs[p % 4]);
            chk(c[1], es[p]);
            chk(c[2], p == 0 ? 0 : (p == 3 ? 64 : 128));
            chk(c[3], p[0] ? (p == 5 ? 64 : 128) : 0);
        end
        $display("test lamps done");
        close_out();
    end
endmodule
